// >>> common/lioreg_pkg.sv
// ****************************************************************
// Low I/O register bank constants
// ****************************************************************
package lioreg_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int LIO_AW = 6;
    localparam int LIO_DW = 8;
    localparam int LIO_BW = 3;
    localparam int LIO_NREG = 64;
    localparam int LIO_PORT_W = 4;
    localparam int LIO_SENSE_W = 2;
    localparam int LIO_CHAN_W = 2;
    localparam int LIO_TRIG_W = 3;
    localparam int LIO_SYNC_W = 5;

    typedef logic [LIO_AW-1:0] lio_addr_t;
    typedef logic [LIO_DW-1:0] lio_byte_t;
    typedef logic [LIO_BW-1:0] lio_bit_t;

    // Highest address that takes single-bit set, clear and test
    localparam lio_addr_t LIO_BIT_ACCESS_TOP = 6'h1f;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam lio_addr_t OFS_PORT_B_PIN_INPUT = 6'h00;
    localparam lio_addr_t OFS_PORT_B_DIRECTION = 6'h01;
    localparam lio_addr_t OFS_PORT_B_OUTPUT_VALUE = 6'h02;
    localparam lio_addr_t OFS_PORT_B_PULLUP_ENABLE = 6'h03;
    localparam lio_addr_t OFS_PORT_CONTROL = 6'h0c;
    localparam lio_addr_t OFS_PIN_CHANGE_MASK = 6'h10;
    localparam lio_addr_t OFS_PIN_CHANGE_FLAG = 6'h11;
    localparam lio_addr_t OFS_PIN_CHANGE_IRQ_CONTROL = 6'h12;
    localparam lio_addr_t OFS_EXT_IRQ_MASK = 6'h13;
    localparam lio_addr_t OFS_EXT_IRQ_FLAG = 6'h14;
    localparam lio_addr_t OFS_EXT_IRQ_SENSE_CONTROL = 6'h15;
    localparam lio_addr_t OFS_DIGITAL_INPUT_DISABLE = 6'h17;
    localparam lio_addr_t OFS_CONVERTER_RESULT = 6'h19;
    localparam lio_addr_t OFS_CONVERTER_CHANNEL_SELECT = 6'h1b;
    localparam lio_addr_t OFS_CONVERTER_TRIGGER_SELECT = 6'h1c;
    localparam lio_addr_t OFS_CONVERTER_CONTROL_STATUS = 6'h1d;
    localparam lio_addr_t OFS_COMPARATOR_CONTROL_STATUS = 6'h1f;
    localparam lio_addr_t OFS_TIMER_CAPTURE_LOW = 6'h22;
    localparam lio_addr_t OFS_TIMER_CAPTURE_HIGH = 6'h23;
    localparam lio_addr_t OFS_TIMER_COMPARE_B_LOW = 6'h24;
    localparam lio_addr_t OFS_TIMER_COMPARE_B_HIGH = 6'h25;
    localparam lio_addr_t OFS_TIMER_COMPARE_A_LOW = 6'h26;
    localparam lio_addr_t OFS_TIMER_COMPARE_A_HIGH = 6'h27;
    localparam lio_addr_t OFS_TIMER_COUNT_LOW = 6'h28;
    localparam lio_addr_t OFS_TIMER_COUNT_HIGH = 6'h29;
    localparam lio_addr_t OFS_TIMER_IRQ_FLAG = 6'h2a;

    // ************************************************************
    // Field positions and reset value
    // ************************************************************
    localparam lio_bit_t BIT_CMP_OUT = 3'h5;
    localparam lio_bit_t BIT_CMP_EVENT = 3'h4;
    localparam lio_bit_t BIT_CONV_START = 3'h6;
    localparam lio_bit_t BIT_CONV_DONE = 3'h4;
    localparam lio_bit_t BIT_TMR_CAPTURE = 3'h5;
    localparam lio_bit_t BIT_TMR_MATCH_B = 3'h2;
    localparam lio_bit_t BIT_TMR_MATCH_A = 3'h1;
    localparam lio_bit_t BIT_TMR_OVERFLOW = 3'h0;
    localparam lio_bit_t BIT_SINGLE_FLAG = 3'h0;
    localparam lio_bit_t BIT_BREAK_BEFORE_MAKE = 3'h1;
    localparam lio_byte_t LIO_RESET_VALUE = 8'h00;
    localparam lio_byte_t LIO_ALL = 8'hff;

    // ************************************************************
    // Bit kinds per address: plain read/write, write-one-to-clear,
    // hardware loaded (read only). Anything else reads as zero.
    // ************************************************************
    function automatic lio_byte_t lio_rw_mask(input lio_addr_t a);
        lio_byte_t m;
        m = 8'h00;
        if (a == OFS_PORT_B_DIRECTION || a == OFS_PORT_B_OUTPUT_VALUE ||
            a == OFS_PORT_B_PULLUP_ENABLE || a == OFS_PIN_CHANGE_MASK ||
            a == OFS_DIGITAL_INPUT_DISABLE)
            m = 8'h0f;
        else if (a == OFS_PORT_CONTROL)
            m = 8'h02;
        else if (a == OFS_PIN_CHANGE_IRQ_CONTROL || a == OFS_EXT_IRQ_MASK)
            m = 8'h01;
        else if (a == OFS_EXT_IRQ_SENSE_CONTROL || a == OFS_CONVERTER_CHANNEL_SELECT)
            m = 8'h03;
        else if (a == OFS_CONVERTER_TRIGGER_SELECT)
            m = 8'h07;
        else if (a == OFS_CONVERTER_CONTROL_STATUS)
            m = 8'hef;
        else if (a == OFS_COMPARATOR_CONTROL_STATUS)
            m = 8'h8f;
        else if (a >= OFS_TIMER_CAPTURE_LOW && a <= OFS_TIMER_COUNT_HIGH)
            m = 8'hff;
        return m;
    endfunction : lio_rw_mask

    function automatic lio_byte_t lio_w1c_mask(input lio_addr_t a);
        lio_byte_t m;
        m = 8'h00;
        if (a == OFS_PIN_CHANGE_FLAG || a == OFS_EXT_IRQ_FLAG)
            m = 8'h01;
        else if (a == OFS_CONVERTER_CONTROL_STATUS || a == OFS_COMPARATOR_CONTROL_STATUS)
            m = 8'h10;
        else if (a == OFS_TIMER_IRQ_FLAG)
            m = 8'h27;
        return m;
    endfunction : lio_w1c_mask

    function automatic lio_byte_t lio_ro_mask(input lio_addr_t a);
        lio_byte_t m;
        m = 8'h00;
        if (a == OFS_PORT_B_PIN_INPUT)
            m = 8'h0f;
        else if (a == OFS_CONVERTER_RESULT)
            m = 8'hff;
        else if (a == OFS_COMPARATOR_CONTROL_STATUS)
            m = 8'h20;
        return m;
    endfunction : lio_ro_mask

endpackage : lioreg_pkg

// >>> common/lioreg_acc_if.sv
`timescale 1ns/1ps
`default_nettype none
// Decoded core write: which bits of which address change, and to what
interface lioreg_acc_if;
    import lioreg_pkg::*;
    logic we;
    lio_addr_t addr;
    lio_byte_t mask;
    lio_byte_t data;
    logic bit_reject;

    modport decoder (output we, output addr, output mask, output data, output bit_reject);
    modport bank (input we, input addr, input mask, input data, input bit_reject);
endinterface : lioreg_acc_if
`default_nettype wire

// >>> design/lioreg_bitop.sv
`timescale 1ns/1ps
`default_nettype none
module lioreg_bitop
    import lioreg_pkg::*;
(
    // Core access strobes
    input wire lio_addr_t io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_bset_i,
    input wire logic io_bclr_i,
    input wire logic io_btst_i,
    input wire lio_bit_t io_bit_i,
    input wire lio_byte_t io_wdata_i,
    // Decoded write
    lioreg_acc_if.decoder acc
);
    // ************************************************************
    // Access decode
    // ************************************************************
    logic in_bit_range;
    logic bit_op;
    lio_byte_t one_hot;

    // Bit ops only reach the low range; above it they are dropped
    assign in_bit_range = io_addr_i <= LIO_BIT_ACCESS_TOP;
    assign bit_op = io_bset_i || io_bclr_i;
    assign one_hot = 8'h01 << io_bit_i;

    // A byte write wins over a bit op if the core ever raises both
    assign acc.we = io_wr_i || (bit_op && in_bit_range);
    assign acc.addr = io_addr_i;
    // Bit ops touch one bit only, so a written one never lands on a flag beside it
    assign acc.mask = io_wr_i ? LIO_ALL : one_hot;
    assign acc.data = io_wr_i ? io_wdata_i : (io_bset_i ? LIO_ALL : 8'h00);
    assign acc.bit_reject = !io_wr_i && (bit_op || io_btst_i) && !in_bit_range;
endmodule : lioreg_bitop
`default_nettype wire

// >>> design/lioreg_bank.sv
`timescale 1ns/1ps
`default_nettype none
module lioreg_bank
    import lioreg_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Core access
    input wire lio_addr_t io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic io_bset_i,
    input wire logic io_bclr_i,
    input wire logic io_btst_i,
    input wire lio_bit_t io_bit_i,
    input wire lio_byte_t io_wdata_i,
    output logic [LIO_DW-1:0] io_rdata_o,
    output logic io_bit_val_o,
    output logic io_reject_o,
    // Asynchronous inputs
    input wire logic [LIO_PORT_W-1:0] port_b_pin_i,
    input wire logic cmp_out_i,
    // Peripheral events, same clock
    input wire logic cmp_event_i,
    input wire logic pin_chg_event_i,
    input wire logic ext_irq_event_i,
    input wire logic conv_done_i,
    input wire lio_byte_t conv_result_i,
    input wire logic tmr_overflow_i,
    input wire logic tmr_match_a_i,
    input wire logic tmr_match_b_i,
    input wire logic tmr_capture_i,
    input wire logic [2*LIO_DW-1:0] tmr_capture_val_i,
    input wire logic tmr_count_ld_i,
    input wire logic [2*LIO_DW-1:0] tmr_count_i,
    // Register contents towards the peripherals
    output logic [LIO_PORT_W-1:0] port_b_dir_o,
    output logic [LIO_PORT_W-1:0] port_b_out_o,
    output logic [LIO_PORT_W-1:0] port_b_pullup_o,
    output logic port_break_before_make_o,
    output logic [LIO_PORT_W-1:0] pin_chg_mask_o,
    output logic pin_chg_flag_o,
    output logic pin_chg_irq_en_o,
    output logic ext_irq_en_o,
    output logic ext_irq_flag_o,
    output logic [LIO_SENSE_W-1:0] ext_irq_sense_o,
    output logic [LIO_PORT_W-1:0] dig_in_dis_o,
    output logic [LIO_CHAN_W-1:0] conv_chan_o,
    output logic [LIO_TRIG_W-1:0] conv_trig_o,
    output logic [LIO_DW-1:0] conv_ctrl_o,
    output logic [LIO_DW-1:0] cmp_ctrl_o,
    output logic [2*LIO_DW-1:0] tmr_capture_o,
    output logic [2*LIO_DW-1:0] tmr_cmp_a_o,
    output logic [2*LIO_DW-1:0] tmr_cmp_b_o,
    output logic [2*LIO_DW-1:0] tmr_count_o,
    output logic [LIO_DW-1:0] tmr_flags_o
);

    // ************************************************************
    // Access decode
    // ************************************************************
    lioreg_acc_if acc ();

    lioreg_bitop u_bitop (
        .io_addr_i (io_addr_i),
        .io_wr_i (io_wr_i),
        .io_bset_i (io_bset_i),
        .io_bclr_i (io_bclr_i),
        .io_btst_i (io_btst_i),
        .io_bit_i (io_bit_i),
        .io_wdata_i (io_wdata_i),
        .acc (acc.decoder)
    );

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [LIO_SYNC_W-1:0] sync_raw;
    logic [LIO_SYNC_W-1:0] sync1_q;
    logic [LIO_SYNC_W-1:0] sync2_q;
    logic [LIO_SYNC_W-1:0] sync3_q;
    logic [LIO_SYNC_W-1:0] stable_q;
    logic [LIO_SYNC_W-1:0] stable_d;
    logic [LIO_SYNC_W-1:0] disagree;

    assign sync_raw = {cmp_out_i, port_b_pin_i};

    // A bit only moves once stages two and three agree, which rejects a
    // level caught mid-change at the cost of one extra cycle of delay
    assign disagree = sync2_q ^ sync3_q;
    assign stable_d = (sync3_q & ~disagree) | (stable_q & disagree);

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            stable_q <= '0;
        end
        else
        begin
            sync1_q <= sync_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            stable_q <= stable_d;
        end
    end

    // ************************************************************
    // Hardware updates per address
    // ************************************************************
    lio_byte_t hw_set [LIO_NREG];
    lio_byte_t hw_clr [LIO_NREG];
    lio_byte_t hw_ldm [LIO_NREG];
    lio_byte_t hw_ldd [LIO_NREG];

    // Routes each peripheral event to the bits it sets, clears or loads
    always_comb
    begin
        for (int i = 0; i < LIO_NREG; i++)
        begin
            hw_set[i] = 8'h00;
            hw_clr[i] = 8'h00;
            hw_ldm[i] = 8'h00;
            hw_ldd[i] = 8'h00;
        end
        hw_ldm[OFS_PORT_B_PIN_INPUT] = LIO_ALL;
        hw_ldd[OFS_PORT_B_PIN_INPUT] = 8'(stable_q[LIO_PORT_W-1:0]);
        hw_ldm[OFS_COMPARATOR_CONTROL_STATUS] = 8'h01 << BIT_CMP_OUT;
        hw_ldd[OFS_COMPARATOR_CONTROL_STATUS] = 8'(stable_q[LIO_PORT_W]) << BIT_CMP_OUT;
        hw_set[OFS_COMPARATOR_CONTROL_STATUS] = 8'(cmp_event_i) << BIT_CMP_EVENT;
        hw_set[OFS_PIN_CHANGE_FLAG] = 8'(pin_chg_event_i) << BIT_SINGLE_FLAG;
        hw_set[OFS_EXT_IRQ_FLAG] = 8'(ext_irq_event_i) << BIT_SINGLE_FLAG;
        hw_ldm[OFS_CONVERTER_RESULT] = conv_done_i ? LIO_ALL : 8'h00;
        hw_ldd[OFS_CONVERTER_RESULT] = conv_result_i;
        hw_set[OFS_CONVERTER_CONTROL_STATUS] = 8'(conv_done_i) << BIT_CONV_DONE;
        hw_clr[OFS_CONVERTER_CONTROL_STATUS] = 8'(conv_done_i) << BIT_CONV_START;
        hw_set[OFS_TIMER_IRQ_FLAG] = (8'(tmr_capture_i) << BIT_TMR_CAPTURE)
            | (8'(tmr_match_b_i) << BIT_TMR_MATCH_B)
            | (8'(tmr_match_a_i) << BIT_TMR_MATCH_A)
            | (8'(tmr_overflow_i) << BIT_TMR_OVERFLOW);
        hw_ldm[OFS_TIMER_CAPTURE_LOW] = tmr_capture_i ? LIO_ALL : 8'h00;
        hw_ldm[OFS_TIMER_CAPTURE_HIGH] = tmr_capture_i ? LIO_ALL : 8'h00;
        hw_ldd[OFS_TIMER_CAPTURE_LOW] = tmr_capture_val_i[LIO_DW-1:0];
        hw_ldd[OFS_TIMER_CAPTURE_HIGH] = tmr_capture_val_i[2*LIO_DW-1:LIO_DW];
        hw_ldm[OFS_TIMER_COUNT_LOW] = tmr_count_ld_i ? LIO_ALL : 8'h00;
        hw_ldm[OFS_TIMER_COUNT_HIGH] = tmr_count_ld_i ? LIO_ALL : 8'h00;
        hw_ldd[OFS_TIMER_COUNT_LOW] = tmr_count_i[LIO_DW-1:0];
        hw_ldd[OFS_TIMER_COUNT_HIGH] = tmr_count_i[2*LIO_DW-1:LIO_DW];
    end

    // ************************************************************
    // Register storage
    // ************************************************************
    lio_byte_t regs_q [LIO_NREG];

    for (genvar a = 0; a < LIO_NREG; a++)
    begin : g_reg
        localparam lio_byte_t RW_M = lio_rw_mask(LIO_AW'(a));
        localparam lio_byte_t W1C_M = lio_w1c_mask(LIO_AW'(a));
        localparam lio_byte_t IMPL_M = RW_M | W1C_M | lio_ro_mask(LIO_AW'(a));
        logic hit;
        lio_byte_t wr_m;
        lio_byte_t loaded;
        lio_byte_t written;
        lio_byte_t d;

        assign hit = acc.we && (acc.addr == LIO_AW'(a));
        // Reserved addresses and bits have empty masks and so never store
        assign wr_m = hit ? acc.mask : 8'h00;
        // Hardware clear goes first so a start written by the core survives
        assign loaded = ((regs_q[a] & ~hw_ldm[a]) | (hw_ldd[a] & hw_ldm[a])) & ~hw_clr[a];
        // Plain bits take the data, flag bits drop only where a one is written
        assign written = ((loaded & ~(wr_m & RW_M)) | (acc.data & wr_m & RW_M))
            & ~(acc.data & wr_m & W1C_M);
        // A flag event in the clearing cycle wins over the clear
        assign d = (written | hw_set[a]) & IMPL_M;

        always_ff @(posedge clock_i)
        begin
            if (!rst_n_i)
                regs_q[a] <= LIO_RESET_VALUE;
            else
                regs_q[a] <= d;
        end
    end

    // ************************************************************
    // Read, bit test and reject answers
    // ************************************************************
    lio_byte_t rd_sel;
    logic test_ok;

    // Reads see the value before any write of the same cycle
    assign rd_sel = regs_q[io_addr_i];
    assign test_ok = io_btst_i && !acc.bit_reject;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            io_rdata_o <= 8'h00;
            io_bit_val_o <= 1'b0;
            io_reject_o <= 1'b0;
        end
        else
        begin
            if (io_rd_i)
                io_rdata_o <= rd_sel;
            if (io_btst_i)
                io_bit_val_o <= test_ok && rd_sel[io_bit_i];
            io_reject_o <= acc.bit_reject;
        end
    end

    // ************************************************************
    // Register contents out, all straight from the storage flops
    // ************************************************************
    assign port_b_dir_o = regs_q[OFS_PORT_B_DIRECTION][LIO_PORT_W-1:0];
    assign port_b_out_o = regs_q[OFS_PORT_B_OUTPUT_VALUE][LIO_PORT_W-1:0];
    assign port_b_pullup_o = regs_q[OFS_PORT_B_PULLUP_ENABLE][LIO_PORT_W-1:0];
    assign port_break_before_make_o = regs_q[OFS_PORT_CONTROL][BIT_BREAK_BEFORE_MAKE];
    assign pin_chg_mask_o = regs_q[OFS_PIN_CHANGE_MASK][LIO_PORT_W-1:0];
    assign pin_chg_flag_o = regs_q[OFS_PIN_CHANGE_FLAG][BIT_SINGLE_FLAG];
    assign pin_chg_irq_en_o = regs_q[OFS_PIN_CHANGE_IRQ_CONTROL][BIT_SINGLE_FLAG];
    assign ext_irq_en_o = regs_q[OFS_EXT_IRQ_MASK][BIT_SINGLE_FLAG];
    assign ext_irq_flag_o = regs_q[OFS_EXT_IRQ_FLAG][BIT_SINGLE_FLAG];
    assign ext_irq_sense_o = regs_q[OFS_EXT_IRQ_SENSE_CONTROL][LIO_SENSE_W-1:0];
    assign dig_in_dis_o = regs_q[OFS_DIGITAL_INPUT_DISABLE][LIO_PORT_W-1:0];
    assign conv_chan_o = regs_q[OFS_CONVERTER_CHANNEL_SELECT][LIO_CHAN_W-1:0];
    assign conv_trig_o = regs_q[OFS_CONVERTER_TRIGGER_SELECT][LIO_TRIG_W-1:0];
    assign conv_ctrl_o = regs_q[OFS_CONVERTER_CONTROL_STATUS];
    assign cmp_ctrl_o = regs_q[OFS_COMPARATOR_CONTROL_STATUS];
    // Bytes of the 16-bit registers are independent; no shadow byte
    assign tmr_capture_o = {regs_q[OFS_TIMER_CAPTURE_HIGH], regs_q[OFS_TIMER_CAPTURE_LOW]};
    assign tmr_cmp_a_o = {regs_q[OFS_TIMER_COMPARE_A_HIGH], regs_q[OFS_TIMER_COMPARE_A_LOW]};
    assign tmr_cmp_b_o = {regs_q[OFS_TIMER_COMPARE_B_HIGH], regs_q[OFS_TIMER_COMPARE_B_LOW]};
    assign tmr_count_o = {regs_q[OFS_TIMER_COUNT_HIGH], regs_q[OFS_TIMER_COUNT_LOW]};
    assign tmr_flags_o = regs_q[OFS_TIMER_IRQ_FLAG];

endmodule : lioreg_bank
`default_nettype wire

// >>> tb/lioreg_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bank port checker
// ****************
module lioreg_bank_checker
    import lioreg_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Core access
    input wire lio_addr_t io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic io_bset_i,
    input wire logic io_bclr_i,
    input wire logic io_btst_i,
    input wire lio_bit_t io_bit_i,
    input wire lio_byte_t io_wdata_i,
    input wire logic [LIO_DW-1:0] io_rdata_o,
    input wire logic io_bit_val_o,
    input wire logic io_reject_o,
    // Watched registers
    input wire logic pin_chg_event_i,
    input wire logic pin_chg_flag_o,
    input wire logic [LIO_PORT_W-1:0] port_b_out_o,
    input wire logic [2*LIO_DW-1:0] tmr_cmp_a_o
);
    // Access decode; a byte write wins over any bit strobe
    wire logic bacc = (io_bset_i || io_bclr_i || io_btst_i) && !io_wr_i;
    wire logic bop = bacc && !io_btst_i;
    wire logic hi = io_addr_i > LIO_BIT_ACCESS_TOP;
    wire logic pout = io_addr_i == OFS_PORT_B_OUTPUT_VALUE && !io_bit_i[2];
    wire logic pfl = io_wr_i && io_addr_i == OFS_PIN_CHANGE_FLAG;

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    // Window edges, bit operations on port output, flag clears and reserved reads
    reject_high_a: assert property (bacc && hi |=> io_reject_o)
        else $error("high bit access not rejected");
    reject_cause_a: assert property (io_reject_o |-> $past(bacc && hi))
        else $error("reject without cause");
    set_bit_a: assert property (bop && io_bset_i && pout |=> port_b_out_o[$past(io_bit_i[1:0])])
        else $error("bit set lost");
    clear_bit_a: assert property (bop && io_bclr_i && pout |=> !port_b_out_o[$past(io_bit_i[1:0])])
        else $error("bit clear lost");
    other_bits_a: assert property (bop && pout |=>
        ((port_b_out_o ^ $past(port_b_out_o)) & ~(4'h1 << $past(io_bit_i[1:0]))) == 4'h0)
        else $error("bit op touched other bits");
    bit_test_a: assert property (bacc && io_btst_i && pout |=> io_bit_val_o == $past(port_b_out_o[io_bit_i[1:0]]))
        else $error("bit test value wrong");
    test_high_a: assert property (bacc && io_btst_i && hi |=> !io_bit_val_o)
        else $error("high bit test not zero");
    high_keep_a: assert property (bop && io_addr_i == OFS_TIMER_COMPARE_A_LOW |=> $stable(tmr_cmp_a_o))
        else $error("high bit op changed register");
    flag_clear_a: assert property (pfl && io_wdata_i[0] && !pin_chg_event_i |=> !pin_chg_flag_o)
        else $error("flag not cleared by one");
    flag_keep_a: assert property (pfl && !io_wdata_i[0] && pin_chg_flag_o |=> pin_chg_flag_o)
        else $error("flag lost on zero write");
    rsvd_read_a: assert property (io_rd_i && (io_addr_i == 6'h04 || io_addr_i == 6'h20) |=> io_rdata_o == 8'h00)
        else $error("reserved address read not zero");
endmodule : lioreg_bank_checker

bind lioreg_bank lioreg_bank_checker u_lioreg_bank_checker (.clock_i, .rst_n_i, .io_addr_i, .io_wr_i,
    .io_rd_i, .io_bset_i, .io_bclr_i, .io_btst_i, .io_bit_i, .io_wdata_i, .io_rdata_o, .io_bit_val_o,
    .io_reject_o, .pin_chg_event_i, .pin_chg_flag_o, .port_b_out_o, .tmr_cmp_a_o);
`default_nettype wire

// >>> tb/lioreg_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Core side of the I/O bus
// ****************
module lioreg_core_model
    import lioreg_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Access towards the bank
    output var lio_addr_t addr_o,
    output var logic wr_o,
    output var logic rd_o,
    output var logic bset_o,
    output var logic bclr_o,
    output var logic btst_o,
    output var lio_bit_t bit_o,
    output var lio_byte_t wdata_o
);
    // One access: kind 0 write, 1 read, 2 set, 3 clear, 4 test.
    // Callers also write reserved bits and reserved places on purpose; the bank must not store them
    task automatic op(input int k, input lio_addr_t a, input lio_bit_t b, input lio_byte_t d);
        @(posedge clock_i);
        #1;
        {addr_o, bit_o, wdata_o} = {a, b, d};
        {wr_o, rd_o, bset_o, bclr_o, btst_o} = 5'h10 >> k;
        @(posedge clock_i);
        #1;
        {wr_o, rd_o, bset_o, bclr_o, btst_o} = 5'h00;
        addr_o = ~a; // Idle bus shows no stale address
        wdata_o = ~d;
    endtask : op

    // Idle bus from time zero
    initial
    begin
        {addr_o, bit_o, wdata_o} = 17'h0;
        {wr_o, rd_o, bset_o, bclr_o, btst_o} = 5'h00;
    end
endmodule : lioreg_core_model
`default_nettype wire

// >>> tb/tb_low_io_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module tb_low_io_register_bank;
    import lioreg_pkg::*;
    // ****************
    // Signals
    // ****************
    logic clock_i, rst_n_i, io_rd_i, io_wr_i, io_bset_i, io_bclr_i, io_btst_i, io_bit_val_o, io_reject_o;
    lio_addr_t io_addr_i;
    lio_bit_t io_bit_i;
    lio_byte_t io_wdata_i, conv_result_i, io_rdata_o, conv_ctrl_o, cmp_ctrl_o, tmr_flags_o;
    logic cmp_out_i, tmr_count_ld_i, port_break_before_make_o, pin_chg_flag_o, pin_chg_irq_en_o;
    logic ext_irq_en_o, ext_irq_flag_o;
    logic [3:0] port_b_pin_i, port_b_dir_o, port_b_out_o, port_b_pullup_o, pin_chg_mask_o, dig_in_dis_o;
    logic [1:0] ext_irq_sense_o, conv_chan_o;
    logic [2:0] conv_trig_o;
    logic [15:0] tmr_capture_val_i, tmr_count_i, tmr_capture_o, tmr_cmp_a_o, tmr_cmp_b_o, tmr_count_o;
    logic [7:0] evt;
    int err_total = 0;
    int total_checks = 0;

    lioreg_bank u_lioreg_bank (.clock_i, .rst_n_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_bset_i, .io_bclr_i,
        .io_btst_i, .io_bit_i, .io_wdata_i, .io_rdata_o, .io_bit_val_o, .io_reject_o, .port_b_pin_i,
        .cmp_out_i, .cmp_event_i(evt[0]), .pin_chg_event_i(evt[1]), .ext_irq_event_i(evt[2]),
        .conv_done_i(evt[3]), .conv_result_i, .tmr_overflow_i(evt[4]), .tmr_match_a_i(evt[5]),
        .tmr_match_b_i(evt[6]), .tmr_capture_i(evt[7]), .tmr_capture_val_i, .tmr_count_ld_i, .tmr_count_i,
        .port_b_dir_o, .port_b_out_o, .port_b_pullup_o, .port_break_before_make_o, .pin_chg_mask_o,
        .pin_chg_flag_o, .pin_chg_irq_en_o, .ext_irq_en_o, .ext_irq_flag_o, .ext_irq_sense_o, .dig_in_dis_o,
        .conv_chan_o, .conv_trig_o, .conv_ctrl_o, .cmp_ctrl_o, .tmr_capture_o, .tmr_cmp_a_o, .tmr_cmp_b_o,
        .tmr_count_o, .tmr_flags_o);

    lioreg_core_model u_lioreg_core_model (.clock_i, .addr_o(io_addr_i), .wr_o(io_wr_i), .rd_o(io_rd_i),
        .bset_o(io_bset_i), .bclr_o(io_bclr_i), .btst_o(io_btst_i), .bit_o(io_bit_i), .wdata_o(io_wdata_i));

    // ****************
    // Helpers
    // ****************
    task automatic acc(input int k, input lio_addr_t a, input int b, input lio_byte_t d);
        u_lioreg_core_model.op(k, a, lio_bit_t'(b), d);
    endtask : acc

    // One-cycle peripheral event pulse
    task automatic ev(input logic [7:0] v);
        @(posedge clock_i);
        #1;
        evt = v;
        @(posedge clock_i);
        #1;
        evt = 8'h00;
    endtask : ev

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    // ****************
    // Scenarios
    // ****************
    task automatic t_byte_rw;
        acc(0, OFS_PORT_B_OUTPUT_VALUE, 0, 8'h05);
        acc(1, OFS_PORT_B_OUTPUT_VALUE, 0, 8'h00);
        `CHK(io_rdata_o, 8'h05)
        acc(0, OFS_PORT_B_DIRECTION, 0, 8'hfa); // Reserved upper bits written on purpose
        acc(1, OFS_PORT_B_DIRECTION, 0, 8'h00);
        `CHK(io_rdata_o, 8'h0a)
    endtask : t_byte_rw

    // Every bit flips, set and clear alternating, each then tested
    task automatic t_bitops;
        for (int i = 0; i < 4; i++)
        begin
            acc(3 - i % 2, OFS_PORT_B_OUTPUT_VALUE, i, 8'h00);
            `CHK(port_b_out_o[i], 1'(i % 2))
            `CHK(io_reject_o, 1'b0)
            acc(4, OFS_PORT_B_OUTPUT_VALUE, i, 8'h00);
            `CHK(io_bit_val_o, 1'(i % 2))
        end
        `CHK(port_b_out_o, 4'ha)
        acc(2, OFS_COMPARATOR_CONTROL_STATUS, 7, 8'h00);
        acc(4, OFS_COMPARATOR_CONTROL_STATUS, 7, 8'h00);
        `CHK({io_bit_val_o, io_reject_o}, 2'h2)
    endtask : t_bitops

    // Flags beside plain bits, then a zero write against a flag
    task automatic t_flags;
        acc(0, OFS_CONVERTER_CONTROL_STATUS, 0, 8'h81);
        ev(8'h08);
        `CHK(conv_ctrl_o, 8'h91)
        acc(2, OFS_CONVERTER_CONTROL_STATUS, 1, 8'h00);
        `CHK(conv_ctrl_o, 8'h93)
        acc(3, OFS_CONVERTER_CONTROL_STATUS, 7, 8'h00);
        `CHK(conv_ctrl_o, 8'h13)
        acc(2, OFS_CONVERTER_CONTROL_STATUS, 4, 8'h00);
        `CHK(conv_ctrl_o, 8'h03)
        acc(1, OFS_CONVERTER_RESULT, 0, 8'h00);
        `CHK(io_rdata_o, 8'h5a)
        ev(8'h02);
        acc(0, OFS_PIN_CHANGE_FLAG, 0, 8'h00);
        `CHK(pin_chg_flag_o, 1'b1)
        acc(0, OFS_PIN_CHANGE_FLAG, 0, 8'h01);
        `CHK(pin_chg_flag_o, 1'b0)
    endtask : t_flags

    // Bit operations on timer registers above the window must bounce
    task automatic t_above;
        acc(0, OFS_TIMER_COMPARE_A_LOW, 0, 8'h3c);
        acc(2, OFS_TIMER_COMPARE_A_LOW, 0, 8'h00);
        `CHK({io_reject_o, tmr_cmp_a_o[7:0]}, 9'h13c)
        ev(8'hf5);
        `CHK(tmr_capture_o, 16'h1234)
        acc(2, OFS_TIMER_IRQ_FLAG, 0, 8'h00);
        `CHK(tmr_flags_o, 8'h27)
        acc(4, OFS_TIMER_IRQ_FLAG, 0, 8'h00);
        `CHK({io_bit_val_o, io_reject_o}, 2'h1)
        acc(0, OFS_TIMER_IRQ_FLAG, 0, 8'h27);
        `CHK(tmr_flags_o, 8'h00)
    endtask : t_above

    // Reserved places read zero; synced inputs show up
    task automatic t_reserved;
        acc(0, 6'h04, 0, 8'hff); // Deliberate breach
        acc(0, 6'h20, 0, 8'hff); // Deliberate breach
        acc(1, 6'h04, 0, 8'h00);
        `CHK(io_rdata_o, 8'h00)
        acc(1, 6'h20, 0, 8'h00);
        `CHK(io_rdata_o, 8'h00)
        acc(1, OFS_PORT_B_PIN_INPUT, 0, 8'h00);
        `CHK(io_rdata_o, 8'h06)
        acc(1, OFS_COMPARATOR_CONTROL_STATUS, 0, 8'h00);
        `CHK(io_rdata_o, 8'hb0)
    endtask : t_reserved

    // ****************
    // Clock, reset, sequence, watchdog
    // ****************
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    initial
    begin
        {rst_n_i, cmp_out_i, tmr_count_ld_i, evt} = 11'h200;
        {port_b_pin_i, conv_result_i, tmr_capture_val_i, tmr_count_i} = {4'h6, 8'h5a, 16'h1234, 16'h0};
        repeat (12) @(posedge clock_i);
        #1;
        rst_n_i = 1'b1;
        t_byte_rw;
        t_bitops;
        t_flags;
        t_above;
        t_reserved;
        report_and_stop;
    end

    // A hung handshake stops the run after far more than the tests need
    initial
    begin
        repeat (4000) @(posedge clock_i);
        err_total++;
        report_and_stop;
    end
endmodule : tb_low_io_register_bank
`default_nettype wire
